// ==== adsp_edge.sv ====
/*
  Edge detector for the host serial clock and chip select. Maps raw edges to
  the launch (read) and sample (write) edges per the idle polarity.
  Assumes pins arrive synchronous to CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
module adsp_edge
(
  input wire logic clk,
  input wire logic rst,
  input wire logic idle_low,
  input wire adsp_pkg::adsp_serial_in_type pins,
  output adsp_pkg::adsp_edge_type edges
);
  logic sclk_d_r;
  logic cs_n_d_r;
  logic rise;
  logic fall;

  // Previous pin levels, used only to spot edges.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclk_d_r <= adsp_pkg::SCLK_IDLE_NORMAL;
      cs_n_d_r <= 1'h1;
    end
    else
    begin
      sclk_d_r <= pins.sclk;
      cs_n_d_r <= pins.cs_n;
    end
  end

  // With an idle-low clock the roles of the two edges swap.
  always_comb
  begin
    rise = pins.sclk & ~sclk_d_r;
    fall = ~pins.sclk & sclk_d_r;
    edges.launch = ~pins.cs_n & (idle_low ? rise : fall);
    edges.sample = ~pins.cs_n & (idle_low ? fall : rise);
    edges.frame_start = ~pins.cs_n & cs_n_d_r;
    edges.frame_end = pins.cs_n & ~cs_n_d_r;
  end
endmodule // adsp_edge
`default_nettype wire

// ==== adsp_host.sv ====
/* Host serial master model framing each transfer with select.
   Assumes the system clock; every move lands just after its rising edge. */
`timescale 1ns/1ps
`default_nettype none
module adsp_host
(
  input wire logic clk,
  input wire logic idle_low,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  // Idle with select high; the clock stands still between frames.
  initial
  begin
    sclk = 1'h1;
    cs_n = 1'h1;
    sdi = 1'h0;
  end
  // Shift the top n bits of w out MSB first and gather the answer in r.
  // With keep set, select stays low afterwards, as on a three-wire bus.
  task automatic xfer(input int n, input bit keep, input logic [23:0] w,
                      output logic [23:0] r);
    r = 24'h000000;
    @(posedge clk) sclk <= ~idle_low;
    @(posedge clk) cs_n <= 1'h0;
    repeat (4) @(posedge clk);
    for (int i = 23; i > 23 - n; i--)
    begin
      sdi <= w[i];
      sclk <= idle_low;
      repeat (4) @(posedge clk);
      r = {r[22:0], sdo};
      sclk <= ~idle_low;
      repeat (4) @(posedge clk);
    end
    if (!keep)
    begin
      cs_n <= 1'h1;
      sdi <= ~sdi; // A released line must not show a stale bit.
    end
  endtask
endmodule // adsp_host
`default_nettype wire

// ==== adsp_pkg.sv ====
/*
  Package for the ADC serial port block: timing counts, word widths and the
  carrier structs shared by the port top and its edge-detect helper.
  Assumes a single 100 MHz system clock.
*/
`default_nettype none
package adsp_pkg;
  // System clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 10000;
  // Least low time of the reset pulse, in nanoseconds.
  localparam int RESET_LOW_MIN_NS = 100;
  // Least reset low time in clock cycles, rounded up, at least one.
  localparam int RESET_LOW_CYC = ((RESET_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS)
                                 < 1 ? 1 :
                                 ((RESET_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Width of one conversion result.
  localparam int RESULT_W = 24;
  // Width of one command word shifted in by the host.
  localparam int CMD_W = 8;
  // Idle level of the serial clock in the normal configuration.
  localparam logic SCLK_IDLE_NORMAL = 1'h1;
  // Reset value of the shift registers.
  localparam logic [RESULT_W-1:0] RESULT_RST = 24'h000000;
  localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
  // Reset value of the serial data output and the data-ready line.
  localparam logic SDO_RST = 1'h1;
  localparam logic DRDY_N_RST = 1'h1;

  // Host-driven serial pins, taken as synchronous to the clock.
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } adsp_serial_in_type;

  // Edge events of the serial clock and select; clock edges already mapped to read and write edges.
  typedef struct packed {
    logic launch;
    logic sample;
    logic frame_start;
    logic frame_end;
  } adsp_edge_type;
endpackage
`default_nettype wire

// ==== adsp_port.sv ====
/*
  Serial port of a multichannel sigma-delta converter: shifts results out
  to the host, takes command bits in, and drives the data-ready line.
  Assumes the host is the serial master and its pins are synchronous to
  CLOCK; the converter core delivers results as one-cycle strobes.
*/
// Operation
// - Clock idles high; idle-low allowed with toggled select, swapping edges.
// - Read data bits are launched on the falling clock edge.
// - Host sets input data before rising edge; device samples there.
// - Data-ready returns high after the first completed result read.
// - While data-ready is high, repeat reads return the same result.
// - Active-low select enables the port; tied low gives three-wire mode.
// - Reset restores power-on state; exit needs reset high and clock. Here RST is active high, so exit needs RST low and CLOCK.
`timescale 1ns/1ps
`default_nettype none
module adsp_port
#(
  parameter int RESULT_W = adsp_pkg::RESULT_W,
  parameter int CMD_W = adsp_pkg::CMD_W
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SCLK_IDLE_LOW,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  input wire logic RESULT_VALID,
  input wire logic [RESULT_W-1:0] RESULT_DATA,
  output logic SDO,
  output logic SDO_OE_N,
  output logic DATA_READY_N,
  output logic [CMD_W-1:0] CMD_DATA,
  output logic CMD_VALID,
  output logic RESET_PULSE_SHORT
);
  adsp_pkg::adsp_serial_in_type pins;
  adsp_pkg::adsp_edge_type edges;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] shift_r;
  logic [$clog2(RESULT_W+1)-1:0] out_cnt_r;
  logic [CMD_W-1:0] cmd_sh_r;
  logic [$clog2(CMD_W+1)-1:0] in_cnt_r;
  logic read_done;
  logic idle_low_r;
  logic [$clog2(adsp_pkg::RESET_LOW_CYC+1)-1:0] rst_cnt_r;

  assign pins = '{sclk: SCLK, cs_n: CS_N, sdi: SDI};

  // Idle polarity is taken only while select is high, so it never flips inside a frame.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      idle_low_r <= 1'h0;
    else if (CS_N)
      idle_low_r <= SCLK_IDLE_LOW;
  end

  adsp_edge u_edge
  (
    .clk(CLOCK),
    .rst(RST),
    .idle_low(idle_low_r),
    .pins(pins),
    .edges(edges)
  );

  // A read completes when the last result bit has been clocked out.
  assign read_done = edges.sample && (out_cnt_r == RESULT_W[$clog2(RESULT_W+1)-1:0] - 1'b1);

  // Output register: a fresh result replaces the held one; otherwise it stays.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      result_r <= adsp_pkg::RESULT_RST;
    else if (RESULT_VALID)
      result_r <= RESULT_DATA;
  end

  // Data-ready: set wins over the clear in the same cycle.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      DATA_READY_N <= adsp_pkg::DRDY_N_RST;
    else if (RESULT_VALID)
      DATA_READY_N <= 1'h0;
    else if (read_done)
      DATA_READY_N <= 1'h1;
  end

  // Read shifter: reload at each frame start so repeats give the same word.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      shift_r <= adsp_pkg::RESULT_RST;
      out_cnt_r <= '0;
      SDO <= adsp_pkg::SDO_RST;
    end
    else if (edges.frame_start || (CS_N == 1'h0 && out_cnt_r == '0 && !edges.launch
             && edges.sample == 1'h0 && SCLK == ~idle_low_r))
    begin
      shift_r <= result_r;
      SDO <= result_r[RESULT_W-1];
      out_cnt_r <= edges.frame_start ? '0 : out_cnt_r;
    end
    else if (edges.launch && out_cnt_r != '0)
    begin
      SDO <= shift_r[RESULT_W-1];
    end
    else if (edges.sample)
    begin
      shift_r <= {shift_r[RESULT_W-2:0], 1'h0};
      out_cnt_r <= (out_cnt_r == RESULT_W[$clog2(RESULT_W+1)-1:0] - 1'b1) ? '0
                   : out_cnt_r + 1'b1;
    end
  end

  // Output pin is driven only while selected; enable is low when driving.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      SDO_OE_N <= 1'h1;
    else
      SDO_OE_N <= CS_N;
  end

  // Command shifter samples input data on the write edge.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      cmd_sh_r <= adsp_pkg::CMD_RST;
      in_cnt_r <= '0;
      CMD_DATA <= adsp_pkg::CMD_RST;
      CMD_VALID <= 1'h0;
    end
    else
    begin
      CMD_VALID <= 1'h0;
      if (edges.frame_start)
        in_cnt_r <= '0;
      else if (edges.sample)
      begin
        cmd_sh_r <= {cmd_sh_r[CMD_W-2:0], SDI};
        if (in_cnt_r == CMD_W[$clog2(CMD_W+1)-1:0] - 1'b1)
        begin
          in_cnt_r <= '0;
          CMD_DATA <= {cmd_sh_r[CMD_W-2:0], SDI};
          CMD_VALID <= 1'h1;
        end
        else
          in_cnt_r <= in_cnt_r + 1'b1;
      end
    end
  end

  // Flags a reset held for fewer cycles than the least pulse width; the
  // design still resets, this only reports the host breaking its timing.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      if (rst_cnt_r != adsp_pkg::RESET_LOW_CYC[$clog2(adsp_pkg::RESET_LOW_CYC+1)-1:0])
        rst_cnt_r <= rst_cnt_r + 1'b1;
      RESET_PULSE_SHORT <= 1'h0;
    end
    else
    begin
      if (rst_cnt_r != '0)
        RESET_PULSE_SHORT <= rst_cnt_r <
          adsp_pkg::RESET_LOW_CYC[$clog2(adsp_pkg::RESET_LOW_CYC+1)-1:0];
      rst_cnt_r <= '0;
    end
  end
endmodule // adsp_port
`default_nettype wire

// ==== adsp_port_props.sv ====
/* Pin checker for the ADC serial port.
   Assumes serial half periods of at least four clocks and steady idle mode per frame. */
`timescale 1ns/1ps
`default_nettype none
module adsp_port_props
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SCLK_IDLE_LOW,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic RESULT_VALID,
  input wire logic SDO,
  input wire logic SDO_OE_N,
  input wire logic DATA_READY_N,
  input wire logic CMD_VALID
);
  // Clock as if it idled high, so one check serves both polarities.
  wire logic h = SCLK ^ SCLK_IDLE_LOW;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_ready_set: assert property (RESULT_VALID |=> !DATA_READY_N)
    else $error("ready not set");
  a_ready_hold: assert property (!DATA_READY_N && CS_N && $past(CS_N) |=> !DATA_READY_N)
    else $error("ready lost while idle");
  a_ready_rise: assert property ($rose(DATA_READY_N) |-> $past(h) && !$past(h, 5))
    else $error("ready rose off edge");
  a_oe_follow: assert property (1 |-> SDO_OE_N == $past(CS_N))
    else $error("enable not following select");
  a_sdo_hold_hi: assert property ((!SCLK_IDLE_LOW && SCLK && !CS_N)[*4] |-> $stable(SDO))
    else $error("data moved while clock high");
  a_sdo_hold_lo: assert property ((SCLK_IDLE_LOW && !SCLK && !CS_N)[*4] |-> $stable(SDO))
    else $error("data moved while clock low");
  a_cmd_sample: assert property (CMD_VALID |-> $past(h) && !$past(h, 5))
    else $error("command off sample edge");
  a_reset_state: assert property (disable iff (1'b0) RST |=> DATA_READY_N && SDO_OE_N && !CMD_VALID)
    else $error("outputs not reset");
  c_read: cover property ($rose(DATA_READY_N));
  c_cmd: cover property (CMD_VALID);
  c_low: cover property (SCLK_IDLE_LOW && !CS_N);
endmodule // adsp_port_props
bind adsp_port adsp_port_props u_props
(.CLOCK(CLOCK), .RST(RST), .SCLK_IDLE_LOW(SCLK_IDLE_LOW), .SCLK(SCLK), .CS_N(CS_N),
 .RESULT_VALID(RESULT_VALID), .SDO(SDO), .SDO_OE_N(SDO_OE_N),
 .DATA_READY_N(DATA_READY_N), .CMD_VALID(CMD_VALID));
`default_nettype wire

// ==== tb_top.sv ====
/* Testbench for the ADC serial port: reset, reads in both polarities, a command.
   Assumes the host model's four-clock serial half period. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic idle_low = 1'h0;
  logic res_valid = 1'h0;
  logic [23:0] res_data = 24'h000000;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, ready_n, cmd_valid, rst_short;
  logic [7:0] cmd_data;
  logic [7:0] cmd_seen = 8'h00;
  logic [23:0] rd;
  int miscompares = 0;
  int checked = 0;
  // A released output floats, so a read of it cannot match.
  wire logic sdo_w = sdo_oe_n ? 1'bz : sdo;
  // The system clock stands in for the master clock and never pauses; its rate is not scaled.
  initial
  begin
    forever #5 clock = ~clock;
  end
  adsp_port u_dut
  (.CLOCK(clock), .RST(rst), .SCLK_IDLE_LOW(idle_low), .SCLK(sclk), .CS_N(cs_n),
   .SDI(sdi), .RESULT_VALID(res_valid), .RESULT_DATA(res_data), .SDO(sdo),
   .SDO_OE_N(sdo_oe_n), .DATA_READY_N(ready_n), .CMD_DATA(cmd_data),
   .CMD_VALID(cmd_valid), .RESET_PULSE_SHORT(rst_short));
  adsp_host u_host
  (.clk(clock), .idle_low(idle_low), .sdo(sdo_w), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  // Keep the last announced command word.
  always @(posedge clock)
  begin
    if (cmd_valid === 1'h1)
      cmd_seen <= cmd_data;
  end
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hold_reset(input int n);
    @(posedge clock) rst <= 1'h1;
    repeat (n) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic push(input logic [23:0] d);
    @(posedge clock) res_valid <= 1'h1;
    res_data <= d;
    @(posedge clock) res_valid <= 1'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic t_reset;
    cmp("ready", 24'h000001, {23'h0, ready_n});
    hold_reset(5);
    cmp("short flag", 24'h000001, {23'h0, rst_short});
    hold_reset(20);
    cmp("short flag", 24'h000000, {23'h0, rst_short});
  endtask
  task automatic t_read;
    push(24'hA5C3F0);
    cmp("ready", 24'h000000, {23'h0, ready_n});
    u_host.xfer(24, 1'b0, 24'h0F0F0F, rd);
    repeat (4) @(posedge clock);
    cmp("result", 24'hA5C3F0, rd);
    cmp("ready", 24'h000001, {23'h0, ready_n});
    u_host.xfer(24, 1'b0, 24'h000000, rd);
    cmp("repeat", 24'hA5C3F0, rd);
  endtask
  task automatic t_idle_low;
    @(posedge clock) idle_low <= 1'h1;
    push(24'h3C5A96);
    u_host.xfer(24, 1'b0, 24'hFFFFFF, rd);
    cmp("low idle result", 24'h3C5A96, rd);
    @(posedge clock) idle_low <= 1'h0;
  endtask
  task automatic t_write;
    u_host.xfer(8, 1'b0, 24'hC60000, rd);
    repeat (4) @(posedge clock);
    cmp("command", 24'h0000C6, {16'h0000, cmd_seen});
  endtask
  // Two reads with select held low; the clock idles high between them.
  task automatic t_three_wire;
    push(24'h5A0F33);
    u_host.xfer(24, 1'b1, 24'h000000, rd);
    cmp("held select result", 24'h5A0F33, rd);
    cmp("enable", 24'h000000, {23'h0, sdo_oe_n});
    push(24'h0CC0AA);
    u_host.xfer(24, 1'b0, 24'h000000, rd);
    repeat (2) @(posedge clock);
    cmp("next held result", 24'h0CC0AA, rd);
    cmp("ready", 24'h000001, {23'h0, ready_n});
    cmp("enable", 24'h000001, {23'h0, sdo_oe_n});
  endtask
  task automatic end_sim;
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cut a hang short well past the expected eleven hundred or so cycles.
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_sim;
  end
  initial
  begin
    hold_reset(20);
    t_reset;
    t_read;
    t_idle_low;
    t_write;
    t_three_wire;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
